// File: inc/upio_pkg.sv
// Package: register map, reset values and field positions of the user ports
// Operation
// - 32 user pins; direction bit 1 is input, 0 drives latch bit.
// - Ports one and two on register bus; three and four via external moves.
// - Register-bus data read returns pins, or latch for read-modify-write.
// - External-space data read returns pin levels; third port reads forced ones until its direction is written.
// - First port data at 90h reset 00h; direction at 91h reset FFh.
// - Second port data at D8h reset 00h; direction at D9h reset FFh.
// - Third port data at 0000h reset 00h; direction 0001h reset FFh.
// - After reset ports one, two undriven; inputs forced to one.
// - Forced state holds until the port's direction register is written.
// - First port bits 0..3 feed timer count and trigger inputs.
// - With bank select, third port pin 7 carries address bit 16.
// - Unused chip-select pins of port four follow its data and direction latches, with no forced state.
// - Fifth port gives two input-only pins, usable as plain inputs.
// - Third port shares the forced reset state until direction written.
// - With bank select, third port pin 7 is an output once the direction register is written.
package upio_pkg;
    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] UPIO_P1_DATA_ADR = 8'h90;
    localparam logic [7:0] UPIO_P1_DIR_ADR = 8'h91;
    localparam logic [7:0] UPIO_P2_DATA_ADR = 8'hd8;
    localparam logic [7:0] UPIO_P2_DIR_ADR = 8'hd9;
    localparam logic [15:0] UPIO_P3_DATA_ADR = 16'h0000;
    localparam logic [15:0] UPIO_P3_DIR_ADR = 16'h0001;
    localparam logic [15:0] UPIO_P4_DATA_ADR = 16'h0003;
    localparam logic [15:0] UPIO_P4_DIR_ADR = 16'h0004;
    localparam logic [15:0] UPIO_P4_CSEN_ADR = 16'h0005;
    localparam logic [15:0] UPIO_P5_ADR = 16'h0006;
    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] UPIO_DATA_RST = 8'h00;
    localparam logic [7:0] UPIO_DIR_RST = 8'hff;
    localparam logic [7:0] UPIO_CSEN_RST = 8'hff;
    localparam logic [7:0] UPIO_FORCED_IN = 8'hff;
    localparam int UPIO_BANK_BIT = 7;
    localparam int UPIO_P5_EN_BIT = 7;
endpackage : upio_pkg

// File: logic/upio_ports.sv
// User programmable I/O ports one to five
`timescale 1ns/100ps
module upio_ports (
    input wire logic ref_clk,
    input wire logic reset_n,
    // Special function register bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_rmw,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // External data space (external data move instruction)
    input wire logic [15:0] xd_addr,
    input wire logic xd_wr,
    input wire logic xd_rd,
    input wire logic [7:0] xd_wdata,
    output logic [7:0] xd_rdata,
    // Bank select takeover of third port pin 7
    input wire logic bank_sel_en,
    input wire logic bank_addr_bit,
    // Chip select drive for fourth port
    input wire logic [7:0] chip_sel_n,
    // Pins
    input wire logic [7:0] first_user_port_i,
    output logic [7:0] first_user_port_o,
    output logic [7:0] first_user_port_oe_n,
    input wire logic [7:0] second_user_port_i,
    output logic [7:0] second_user_port_o,
    output logic [7:0] second_user_port_oe_n,
    input wire logic [7:0] third_user_port_i,
    output logic [7:0] third_user_port_o,
    output logic [7:0] third_user_port_oe_n,
    input wire logic [7:0] chip_select_capable_port_i,
    output logic [7:0] chip_select_capable_port_o,
    output logic [7:0] chip_select_capable_port_oe_n,
    input wire logic [1:0] wakeup_input_port_i,
    // Timer inputs
    output logic timer0_count_input,
    output logic timer1_count_input,
    output logic timer2_external_trigger,
    output logic timer2_count_input
);
    import upio_pkg::*;

    logic [7:0] p1_data_q, p1_dir_q, p2_data_q, p2_dir_q;
    logic [7:0] p3_data_q, p3_dir_q, p4_data_q, p4_dir_q, p4_csen_q;
    logic p5_en_q;
    logic p1_free_q, p2_free_q, p3_free_q;
    logic [7:0] p1_in, p2_in, p3_in, p4_in;
    logic [1:0] p5_in;
    logic [7:0] p3_oe_n_d, p3_o_d, p4_oe_n_d, p4_o_d;
    logic [7:0] sfr_rdata_d, xd_rdata_d;
    logic w_p1_data, w_p1_dir, w_p2_data, w_p2_dir;
    logic w_p3_data, w_p3_dir, w_p4_data, w_p4_dir, w_p4_csen, w_p5;

    // Merge pin level with forced-one input state
    function automatic logic [7:0] upio_in(input logic free,
                                           input logic [7:0] pins);
        upio_in = free ? pins : UPIO_FORCED_IN;
    endfunction

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // bus placement
    assign w_p1_data = sfr_wr && (sfr_addr == UPIO_P1_DATA_ADR);
    assign w_p1_dir = sfr_wr && (sfr_addr == UPIO_P1_DIR_ADR);
    assign w_p2_data = sfr_wr && (sfr_addr == UPIO_P2_DATA_ADR);
    assign w_p2_dir = sfr_wr && (sfr_addr == UPIO_P2_DIR_ADR);
    assign w_p3_data = xd_wr && (xd_addr == UPIO_P3_DATA_ADR);
    assign w_p3_dir = xd_wr && (xd_addr == UPIO_P3_DIR_ADR);
    assign w_p4_data = xd_wr && (xd_addr == UPIO_P4_DATA_ADR);
    assign w_p4_dir = xd_wr && (xd_addr == UPIO_P4_DIR_ADR);
    assign w_p4_csen = xd_wr && (xd_addr == UPIO_P4_CSEN_ADR);
    assign w_p5 = xd_wr && (xd_addr == UPIO_P5_ADR);

    // ------------------------------------------------------------------
    // Internal input values
    // ------------------------------------------------------------------
    // forced ones on ports one to three; fifth port reads zero until enabled
    assign p1_in = upio_in(p1_free_q, first_user_port_i);
    assign p2_in = upio_in(p2_free_q, second_user_port_i);
    assign p3_in = upio_in(p3_free_q, third_user_port_i);
    assign p4_in = chip_select_capable_port_i;
    assign p5_in = p5_en_q ? wakeup_input_port_i : 2'b00;

    // ------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------
    // pins or latch
    always_comb begin
        sfr_rdata_d = 8'h00;
        unique case (sfr_addr)
            UPIO_P1_DATA_ADR: sfr_rdata_d = sfr_rmw ? p1_data_q : p1_in;
            UPIO_P1_DIR_ADR: sfr_rdata_d = p1_dir_q;
            UPIO_P2_DATA_ADR: sfr_rdata_d = sfr_rmw ? p2_data_q : p2_in;
            UPIO_P2_DIR_ADR: sfr_rdata_d = p2_dir_q;
            default: sfr_rdata_d = 8'h00;
        endcase
    end

    always_comb begin
        xd_rdata_d = 8'h00;
        unique case (xd_addr)
            UPIO_P3_DATA_ADR: xd_rdata_d = p3_in;
            UPIO_P3_DIR_ADR: xd_rdata_d = p3_dir_q;
            UPIO_P4_DATA_ADR: xd_rdata_d = p4_in;
            UPIO_P4_DIR_ADR: xd_rdata_d = p4_dir_q;
            UPIO_P4_CSEN_ADR: xd_rdata_d = p4_csen_q;
            UPIO_P5_ADR: xd_rdata_d = {p5_en_q, p5_in[0], p5_in[1], 5'h00};
            default: xd_rdata_d = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Third and fourth port pin drive
    // ------------------------------------------------------------------
    // bank bit replaces latch bit 7
    assign p3_o_d = bank_sel_en ? {bank_addr_bit, p3_data_q[6:0]} : p3_data_q;
    assign p3_oe_n_d = !p3_free_q ? 8'hff :
        (bank_sel_en ? {1'b0, p3_dir_q[6:0]} : p3_dir_q);
    // general purpose where chip select off
    assign p4_o_d = (p4_csen_q & chip_sel_n) | (~p4_csen_q & p4_data_q);
    assign p4_oe_n_d = ~p4_csen_q & p4_dir_q;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // first port registers; latch stores regardless of direction
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            p1_data_q <= UPIO_DATA_RST;
            p1_dir_q <= UPIO_DIR_RST;
        end else begin
            if (w_p1_data) p1_data_q <= sfr_wdata;
            if (w_p1_dir) p1_dir_q <= sfr_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            p2_data_q <= UPIO_DATA_RST;
            p2_dir_q <= UPIO_DIR_RST;
        end else begin
            if (w_p2_data) p2_data_q <= sfr_wdata;
            if (w_p2_dir) p2_dir_q <= sfr_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            p3_data_q <= UPIO_DATA_RST;
            p3_dir_q <= UPIO_DIR_RST;
        end else begin
            if (w_p3_data) p3_data_q <= xd_wdata;
            if (w_p3_dir) p3_dir_q <= xd_wdata;
        end
    end

    // Fourth and fifth port registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            p4_data_q <= UPIO_DATA_RST;
            p4_dir_q <= UPIO_DIR_RST;
            p4_csen_q <= UPIO_CSEN_RST;
            p5_en_q <= 1'b0;
        end else begin
            if (w_p4_data) p4_data_q <= xd_wdata;
            if (w_p4_dir) p4_dir_q <= xd_wdata;
            if (w_p4_csen) p4_csen_q <= xd_wdata;
            if (w_p5) p5_en_q <= xd_wdata[UPIO_P5_EN_BIT];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            p1_free_q <= 1'b0;
            p2_free_q <= 1'b0;
            p3_free_q <= 1'b0;
        end else begin
            if (w_p1_dir) p1_free_q <= 1'b1;
            if (w_p2_dir) p2_free_q <= 1'b1;
            if (w_p3_dir) p3_free_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    // direction and data drive pins
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            first_user_port_o <= 8'h00;
            first_user_port_oe_n <= 8'hff;
            second_user_port_o <= 8'h00;
            second_user_port_oe_n <= 8'hff;
            third_user_port_o <= 8'h00;
            third_user_port_oe_n <= 8'hff;
            chip_select_capable_port_o <= 8'hff;
            chip_select_capable_port_oe_n <= 8'h00;
        end else begin
            first_user_port_o <= p1_data_q;
            first_user_port_oe_n <= p1_free_q ? p1_dir_q : 8'hff;
            second_user_port_o <= p2_data_q;
            second_user_port_oe_n <= p2_free_q ? p2_dir_q : 8'hff;
            third_user_port_o <= p3_o_d;
            third_user_port_oe_n <= p3_oe_n_d;
            chip_select_capable_port_o <= p4_o_d;
            chip_select_capable_port_oe_n <= p4_oe_n_d;
        end
    end

    // timer inputs; software keeps these pins as inputs
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer0_count_input <= 1'b1;
            timer1_count_input <= 1'b1;
            timer2_external_trigger <= 1'b1;
            timer2_count_input <= 1'b1;
            sfr_rdata <= 8'h00;
            xd_rdata <= 8'h00;
        end else begin
            timer0_count_input <= p1_in[0];
            timer1_count_input <= p1_in[1];
            timer2_external_trigger <= p1_in[2];
            timer2_count_input <= p1_in[3];
            if (sfr_rd) sfr_rdata <= sfr_rdata_d;
            if (xd_rd) xd_rdata <= xd_rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_P1_FORCED_OFF: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        !p1_free_q |=> first_user_port_oe_n == 8'hff)
        else $error("first port drove before direction write");
    AST_P1_RELEASE: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        w_p1_dir |=> p1_free_q ##1 first_user_port_oe_n == $past(p1_dir_q))
        else $error("first port not released by direction write");
    AST_P1_DRIVE: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        p1_free_q |=> first_user_port_oe_n == $past(p1_dir_q)
            && first_user_port_o == $past(p1_data_q))
        else $error("first port drive mismatch");
    AST_SFR_RMW: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        sfr_rd && sfr_rmw && sfr_addr == UPIO_P2_DATA_ADR
            |=> sfr_rdata == $past(p2_data_q))
        else $error("read-modify-write read not latch");
    AST_XD_PINS: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        xd_rd && xd_addr == UPIO_P3_DATA_ADR && p3_free_q
            |=> xd_rdata == $past(third_user_port_i))
        else $error("external read not pins");
    AST_P3_FORCED: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        xd_rd && xd_addr == UPIO_P3_DATA_ADR && !p3_free_q
            |=> xd_rdata == UPIO_FORCED_IN)
        else $error("third port input not forced");
    AST_BANK_PIN: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        bank_sel_en && p3_free_q |=> !third_user_port_oe_n[UPIO_BANK_BIT]
            && third_user_port_o[UPIO_BANK_BIT] == $past(bank_addr_bit))
        else $error("bank pin not driven with address bit");
    AST_TIMER0: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        1'b1 |=> timer0_count_input == $past(p1_in[0]))
        else $error("timer input not from first port bit 0");
    AST_P2_FORCED_OFF: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        !p2_free_q |=> second_user_port_oe_n == 8'hff)
        else $error("second port drove before direction write");
    AST_P2_DRIVE: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        p2_free_q |=> second_user_port_oe_n == $past(p2_dir_q)
            && second_user_port_o == $past(p2_data_q))
        else $error("second port drive mismatch");
    AST_P3_FORCED_OFF: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        !p3_free_q |=> third_user_port_oe_n == 8'hff)
        else $error("third port drove before direction write");
    AST_P3_DRIVE: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        p3_free_q && !bank_sel_en
            |=> third_user_port_oe_n == $past(p3_dir_q)
            && third_user_port_o == $past(p3_data_q))
        else $error("third port drive mismatch");
    AST_P3_LOW_BITS: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        bank_sel_en && p3_free_q
            |=> third_user_port_o[6:0] == $past(p3_data_q[6:0])
            && third_user_port_oe_n[6:0] == $past(p3_dir_q[6:0]))
        else $error("bank select disturbed third port low bits");
    AST_SFR_PINS: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        sfr_rd && !sfr_rmw && sfr_addr == UPIO_P1_DATA_ADR && p1_free_q
            |=> sfr_rdata == $past(first_user_port_i))
        else $error("register bus read not pins");
    AST_LATCH_STORE: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        w_p1_data |=> p1_data_q == $past(sfr_wdata))
        else $error("first port latch write lost");
    AST_P1_DIR_STORE: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        w_p1_dir |=> p1_dir_q == $past(sfr_wdata))
        else $error("first port direction write lost");
    AST_TIMER_REST: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        1'b1 |=> {timer2_count_input, timer2_external_trigger,
            timer1_count_input} == $past(p1_in[3:1]))
        else $error("timer inputs not from first port bits 1 to 3");
    // general purpose pins of fourth port
    AST_P4_GPIO: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        1'b1 |=> ((chip_select_capable_port_oe_n ^ $past(p4_dir_q))
            & ~$past(p4_csen_q)) == 8'h00
            && ((chip_select_capable_port_o ^ $past(p4_data_q))
            & ~$past(p4_csen_q)) == 8'h00)
        else $error("fourth port pin not following its registers");
    AST_SFR_UNMAPPED: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        sfr_rd && sfr_addr != UPIO_P1_DATA_ADR
            && sfr_addr != UPIO_P1_DIR_ADR
            && sfr_addr != UPIO_P2_DATA_ADR
            && sfr_addr != UPIO_P2_DIR_ADR
            |=> sfr_rdata == 8'h00)
        else $error("unmapped register read not zero");
    AST_P5_MASK: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        xd_rd && xd_addr == UPIO_P5_ADR && !p5_en_q
            |=> xd_rdata[6:5] == 2'b00)
        else $error("disabled fifth port pins visible");
endmodule // upio_ports

// File: tb/upio_pin_model.sv
// Board model: resolves each user pin from port drive and board level
`timescale 1ns/100ps
module upio_pin_model (
    input wire logic [7:0] drive,
    input wire logic [7:0] drive_en_n,
    input wire logic [7:0] board,
    output logic [7:0] pin
);
    // Driven bits follow the port, released bits the board
    assign pin = (drive & ~drive_en_n) | (board & drive_en_n);
endmodule // upio_pin_model

// File: tb/upio_ports_tb.sv
// Self-checking testbench for the user I/O port block
`timescale 1ns/100ps
module upio_ports_tb;
    import upio_pkg::*;
    logic ref_clk = 1'b0, reset_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, xd_wdata = 8'h00;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0, xd_wr = 1'b0;
    logic xd_rd = 1'b0, bank_sel_en = 1'b0, bank_addr_bit = 1'b0;
    logic [15:0] xd_addr = 16'h0000;
    logic [7:0] xd_rdata, chip_sel_n = 8'hff, rd;
    logic [7:0] b1 = 8'h3c, b2 = 8'h00, b3 = 8'h00, b4 = 8'hff;
    logic [7:0] first_user_port_i, first_user_port_o, first_user_port_oe_n;
    logic [7:0] second_user_port_i, second_user_port_o, second_user_port_oe_n;
    logic [7:0] third_user_port_i, third_user_port_o, third_user_port_oe_n;
    logic [7:0] chip_select_capable_port_i, chip_select_capable_port_o;
    logic [7:0] chip_select_capable_port_oe_n;
    logic [1:0] wakeup_input_port_i = 2'b00;
    logic timer0_count_input, timer1_count_input;
    logic timer2_external_trigger, timer2_count_input;
    int num_errors = 0, n_compared = 0, cycles = 0;

    always #5 ref_clk = ~ref_clk;

    upio_ports uut (.ref_clk, .reset_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_rmw,
        .sfr_wdata, .sfr_rdata, .xd_addr, .xd_wr, .xd_rd, .xd_wdata, .xd_rdata,
        .bank_sel_en, .bank_addr_bit, .chip_sel_n, .first_user_port_i,
        .first_user_port_o, .first_user_port_oe_n, .second_user_port_i,
        .second_user_port_o, .second_user_port_oe_n, .third_user_port_i,
        .third_user_port_o, .third_user_port_oe_n, .chip_select_capable_port_i,
        .chip_select_capable_port_o, .chip_select_capable_port_oe_n,
        .wakeup_input_port_i, .timer0_count_input, .timer1_count_input,
        .timer2_external_trigger, .timer2_count_input);

    // ------------------------------------------------------------------
    // Board models on the four bidirectional ports
    // ------------------------------------------------------------------
    upio_pin_model m1 (.drive(first_user_port_o), .drive_en_n(first_user_port_oe_n),
        .board(b1), .pin(first_user_port_i));
    upio_pin_model m2 (.drive(second_user_port_o),
        .drive_en_n(second_user_port_oe_n), .board(b2), .pin(second_user_port_i));
    upio_pin_model m3 (.drive(third_user_port_o), .drive_en_n(third_user_port_oe_n),
        .board(b3), .pin(third_user_port_i));
    upio_pin_model m4 (.drive(chip_select_capable_port_o),
        .drive_en_n(chip_select_capable_port_oe_n), .board(b4),
        .pin(chip_select_capable_port_i));

    // ------------------------------------------------------------------
    // Access tasks, comparison and closing report
    // ------------------------------------------------------------------
    task sw(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk) begin sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1; end
        @(negedge ref_clk) sfr_wr = 1'b0;
        @(negedge ref_clk);
    endtask
    task sr(input logic [7:0] a, input logic m, output logic [7:0] d);
        @(negedge ref_clk) begin sfr_addr = a; sfr_rmw = m; sfr_rd = 1'b1; end
        @(negedge ref_clk) begin d = sfr_rdata; sfr_rd = 1'b0; sfr_rmw = 1'b0; end
    endtask
    task xw(input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk) begin xd_addr = a; xd_wdata = d; xd_wr = 1'b1; end
        @(negedge ref_clk) xd_wr = 1'b0;
        @(negedge ref_clk);
    endtask
    task xr(input logic [15:0] a, output logic [7:0] d);
        @(negedge ref_clk) begin xd_addr = a; xd_rd = 1'b1; end
        @(negedge ref_clk) begin d = xd_rdata; xd_rd = 1'b0; end
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function automatic logic [7:0] tmr();
        return {4'h0, timer2_count_input, timer2_external_trigger,
            timer1_count_input, timer0_count_input};
    endfunction

    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            summarize();
        end
    end

    initial begin
        repeat (10) @(negedge ref_clk);
        reset_n = 1'b1;
        chk(first_user_port_oe_n & second_user_port_oe_n, 8'hff);
        chk(third_user_port_oe_n, 8'hff);
        sr(UPIO_P1_DATA_ADR, 1'b0, rd); chk(rd, UPIO_FORCED_IN);
        sr(UPIO_P1_DIR_ADR, 1'b0, rd); chk(rd, 8'hff);
        sr(UPIO_P1_DATA_ADR, 1'b1, rd); chk(rd, 8'h00);
        chk(tmr(), 8'h0f);
        sr(UPIO_P2_DIR_ADR, 1'b0, rd); chk(rd, 8'hff);
        sr(UPIO_P2_DATA_ADR, 1'b1, rd); chk(rd, 8'h00);
        xr(UPIO_P3_DATA_ADR, rd); chk(rd, UPIO_FORCED_IN);
        xr(UPIO_P3_DIR_ADR, rd); chk(rd, 8'hff);
        $display("test reset state done");
        sw(UPIO_P1_DATA_ADR, 8'ha5);
        chk(first_user_port_oe_n, 8'hff);
        sw(UPIO_P1_DIR_ADR, 8'hf0);
        chk(first_user_port_oe_n, 8'hf0);
        chk(first_user_port_o & ~first_user_port_oe_n, 8'h05);
        sr(UPIO_P1_DATA_ADR, 1'b0, rd); chk(rd, 8'h35);
        sr(UPIO_P1_DATA_ADR, 1'b1, rd); chk(rd, 8'ha5);
        chk(tmr(), 8'h05);
        // Board level set first, then timer pins set as inputs
        b1 = 8'h0a;
        sw(UPIO_P1_DIR_ADR, 8'hff);
        repeat (2) @(negedge ref_clk);
        chk(tmr(), 8'h0a);
        $display("test first port done");
        sw(UPIO_P2_DATA_ADR, 8'h3c);
        sw(UPIO_P2_DIR_ADR, 8'h00);
        chk(second_user_port_o & ~second_user_port_oe_n, 8'h3c);
        sr(UPIO_P2_DATA_ADR, 1'b0, rd); chk(rd, 8'h3c);
        sr(8'h55, 1'b0, rd); chk(rd, 8'h00);
        $display("test second port done");
        xw(UPIO_P3_DATA_ADR, 8'h81);
        xw(UPIO_P3_DIR_ADR, 8'h00);
        chk(third_user_port_o & ~third_user_port_oe_n, 8'h81);
        xr(UPIO_P3_DATA_ADR, rd); chk(rd, 8'h81);
        xr(UPIO_P3_DIR_ADR, rd); chk(rd, 8'h00);
        bank_sel_en = 1'b1;
        xw(UPIO_P3_DIR_ADR, 8'hff);
        chk(third_user_port_oe_n, 8'h7f);
        chk({7'h00, third_user_port_o[UPIO_BANK_BIT]}, 8'h00);
        bank_addr_bit = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk({7'h00, third_user_port_o[UPIO_BANK_BIT]}, 8'h01);
        $display("test third port done");
        chip_sel_n = 8'h3c;
        repeat (2) @(negedge ref_clk);
        chk(chip_select_capable_port_o, 8'h3c);
        xw(UPIO_P4_CSEN_ADR, 8'h00);
        xw(UPIO_P4_DIR_ADR, 8'h00);
        xw(UPIO_P4_DATA_ADR, 8'h5a);
        chk(chip_select_capable_port_oe_n, 8'h00);
        chk(chip_select_capable_port_o, 8'h5a);
        xr(UPIO_P4_DATA_ADR, rd); chk(rd, 8'h5a);
        wakeup_input_port_i = 2'b10;
        xr(UPIO_P5_ADR, rd); chk(rd, 8'h00);
        xw(UPIO_P5_ADR, 8'h80);
        xr(UPIO_P5_ADR, rd); chk(rd, 8'ha0);
        xr(16'h0007, rd); chk(rd, 8'h00);
        $display("test fourth and fifth port done");
        // Second reset brings back the forced state
        reset_n = 1'b0;
        repeat (3) @(negedge ref_clk);
        reset_n = 1'b1;
        chk(second_user_port_oe_n & third_user_port_oe_n, 8'hff);
        sr(UPIO_P2_DATA_ADR, 1'b0, rd); chk(rd, UPIO_FORCED_IN);
        chk(tmr(), 8'h0f);
        $display("test second reset done");
        summarize();
    end
endmodule // upio_ports_tb
